// [rtl/lcdms_osc.sv]
/*
  lcdms_osc: the built-in oscillator amplifier. An inverting stage whose
  loop is closed by the external feedback resistor between the two pins.
  assumes: feedback pin sampled synchronously, enable held steady per mode.
*/
`timescale 1ns/1ns
`default_nettype none

module lcdms_osc
  import lcdms_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic osc_feedback_in,
  output logic      osc_amp_out,
  output logic      osc_amp_oe
);

  lcdms_osc_s s_reg;
  lcdms_osc_s s_next;

  ////////////////////////////////////////////////////////////////////////////
  // inverting amplifier; parked low and undriven while disabled
  always_comb begin
    s_next         = s_reg;
    s_next.amp_oe  = enable;
    s_next.amp_out = enable ? ~osc_feedback_in : 1'b0;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_reg <= LCDMS_OSC_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign osc_amp_out = s_reg.amp_out;
  assign osc_amp_oe  = s_reg.amp_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_osc_inverts: assert property (@(posedge clock) disable iff (reset)
    enable |=> (osc_amp_oe && osc_amp_out == !$past(osc_feedback_in)))
    else $error("oscillator amplifier does not invert feedback");

endmodule

`default_nettype wire

// [rtl/lcdms_pkg.sv]
/*
  lcdms_pkg: shared constants, mode enumeration and state records for the
  master/slave timing control of a dot-matrix display driver.
  assumes: one 10 MHz clock, synchronous active-high reset.
*/
package lcdms_pkg;

  // line counter width and frame length default
  localparam int          LCDMS_LINE_W     = 8;
  localparam logic [7:0]  LCDMS_LINES_DEF  = 8'h40;   // lines per frame, plain default
  localparam logic [7:0]  LCDMS_LINE_ZERO  = 8'h00;
  localparam logic [7:0]  LCDMS_LINE_STEP  = 8'h01;

  // clock rate, kept for derived timing if ever needed
  localparam int          LCDMS_CLOCK_HZ   = 10_000_000;

  // operating mode, decided once from the strap after reset
  typedef enum logic [1:0] {
    LCDMS_STRAP  = 2'b00,
    LCDMS_SLAVE  = 2'b01,
    LCDMS_MASTER = 2'b10
  } lcdms_mode_e;

  // whole state of the timing core
  typedef struct packed {
    lcdms_mode_e               mode;
    logic [LCDMS_LINE_W-1:0]   line;        // line counter
    logic [LCDMS_LINE_W-1:0]   pattern;     // line presented to the drivers
    logic                      tick_prev;   // previous line clock level
    logic                      sync_prev;   // previous sync input level
    logic                      ac_level;    // polarity in effect
    logic                      ac_oe;
    logic                      sync_out;
    logic                      sync_oe;
    logic                      master;      // master flag, kept in its own flop
  } lcdms_state_s;

  // whole state of the oscillator amplifier
  typedef struct packed {
    logic amp_out;
    logic amp_oe;
  } lcdms_osc_s;

  localparam lcdms_state_s LCDMS_STATE_RST = '{
    mode: LCDMS_STRAP, line: 8'h00, pattern: 8'h00, tick_prev: 1'b0,
    sync_prev: 1'b0, ac_level: 1'b0, ac_oe: 1'b0, sync_out: 1'b0, sync_oe: 1'b0,
    master: 1'b0};

  localparam lcdms_osc_s LCDMS_OSC_RST = '{amp_out: 1'b0, amp_oe: 1'b0};

endpackage

// [rtl/lcdms_timing.sv]
/*
  lcdms_timing: master/slave timing control of a display column driver.
  A strap picks master or slave once after reset. The master runs the
  oscillator and drives polarity and sync; a slave follows both pins.
  assumes: all inputs synchronous to clock; the line clock is slower than
  clock/2; the strap is stable when reset releases.
*/
`timescale 1ns/1ns
`default_nettype none

module lcdms_timing
  import lcdms_pkg::*;
#(
  parameter logic [LCDMS_LINE_W-1:0] LINES_PER_FRAME = LCDMS_LINES_DEF
)(
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic                    master_select,
  input  wire logic                    osc_feedback_in,
  output logic                         osc_amp_out,
  output logic                         osc_amp_oe,
  input  wire logic                    row_tick_input,
  input  wire logic                    ac_polarity_signal_in,
  output logic                         ac_polarity_signal_out,
  output logic                         ac_polarity_signal_oe,
  input  wire logic                    display_sync_in,
  output logic                         display_sync_out,
  output logic                         display_sync_oe,
  output logic                         is_master,
  output logic                         ac_polarity_level,
  output logic [LCDMS_LINE_W-1:0]      line_pattern
);

  localparam logic [LCDMS_LINE_W-1:0] LAST_LINE = LINES_PER_FRAME - LCDMS_LINE_STEP;

  lcdms_state_s s_reg;
  lcdms_state_s s_next;
  logic         tick_rise;
  logic         tick_fall;
  logic         sync_rise;

  ////////////////////////////////////////////////////////////////////////////
  // edges of the line clock and of the incoming sync pin
  assign tick_rise = row_tick_input & ~s_reg.tick_prev;
  assign tick_fall = ~row_tick_input & s_reg.tick_prev;
  assign sync_rise = display_sync_in & ~s_reg.sync_prev;

  ////////////////////////////////////////////////////////////////////////////
  // next state: mode decode, counter, polarity and sync handling
  always_comb begin
    s_next           = s_reg;
    s_next.tick_prev = row_tick_input;
    s_next.sync_prev = display_sync_in;
    s_next.sync_out  = 1'b0;                 // sync is a one-cycle pulse
    case (s_reg.mode)
      // strap caught one clock after release, never under reset itself
      LCDMS_STRAP: begin
        s_next.mode = master_select ? LCDMS_MASTER : LCDMS_SLAVE;
      end
      LCDMS_MASTER: begin
        s_next.master  = 1'b1;
        s_next.ac_oe   = 1'b1;
        s_next.sync_oe = 1'b1;
        if (tick_rise) begin
          if (s_reg.line >= LAST_LINE) begin
            // frame wrap: flip polarity for every listener on the net
            s_next.line     = LCDMS_LINE_ZERO;
            s_next.ac_level = ~s_reg.ac_level;
            s_next.sync_out = 1'b1;
          end else begin
            s_next.line = s_reg.line + LCDMS_LINE_STEP;
          end
        end
      end
      LCDMS_SLAVE: begin
        s_next.master   = 1'b0;
        s_next.ac_oe    = 1'b0;
        s_next.sync_oe  = 1'b0;
        s_next.ac_level = ac_polarity_signal_in;
        if (sync_rise) begin
          // master's frame start wins over our own count
          s_next.line = LCDMS_LINE_ZERO;
        end else if (tick_rise) begin
          s_next.line = (s_reg.line >= LAST_LINE) ? LCDMS_LINE_ZERO
                                                  : s_reg.line + LCDMS_LINE_STEP;
        end
      end
      // an unused mode code falls back to the strap state instead of locking up
      default: begin
        s_next = LCDMS_STATE_RST;
      end
    endcase
    // pattern changes only on the falling edge, half a line after the count
    if (tick_fall && s_reg.mode != LCDMS_STRAP) begin
      s_next.pattern = s_reg.line;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock) begin
    if (reset) begin
      s_reg <= LCDMS_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator amplifier, enabled only as master
  lcdms_osc u_osc (
    .clock           (clock),
    .reset           (reset),
    .enable          (s_reg.mode == LCDMS_MASTER),
    .osc_feedback_in (osc_feedback_in),
    .osc_amp_out     (osc_amp_out),
    .osc_amp_oe      (osc_amp_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  // the common driver taps ac_polarity_signal_out from the master only
  assign ac_polarity_signal_out = s_reg.ac_level;
  assign ac_polarity_signal_oe  = s_reg.ac_oe;
  assign display_sync_out       = s_reg.sync_out;
  assign display_sync_oe        = s_reg.sync_oe;
  assign is_master              = s_reg.master;      // own flop, one edge after the mode
  assign ac_polarity_level      = s_reg.ac_level;
  assign line_pattern           = s_reg.pattern;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_osc_slave_off: assert property (
    (s_reg.mode == LCDMS_SLAVE) |=> !osc_amp_oe && !osc_amp_out)
    else $error("oscillator active in slave mode");

  a_ac_pin_dir: assert property (
    (s_reg.mode != LCDMS_STRAP && $past(s_reg.mode) != LCDMS_STRAP) |->
      (ac_polarity_signal_oe == (s_reg.mode == LCDMS_MASTER)))
    else $error("polarity pin direction does not match mode");

  a_ac_slave_follow: assert property (
    (s_reg.mode == LCDMS_SLAVE) |=> ac_polarity_level == $past(ac_polarity_signal_in))
    else $error("slave polarity does not follow the shared net");

  a_frame_flip: assert property (
    (s_reg.mode == LCDMS_MASTER && tick_rise && s_reg.line >= LAST_LINE) |=>
      display_sync_out ##1 !display_sync_out)
    else $error("master frame wrap without one-cycle sync pulse");

  a_frame_polarity: assert property (
    (s_reg.mode == LCDMS_MASTER && tick_rise && s_reg.line >= LAST_LINE) |=>
      ac_polarity_signal_out != $past(ac_polarity_signal_out))
    else $error("polarity not reversed at frame wrap");

  a_sync_pin_dir: assert property (
    (s_reg.mode == LCDMS_SLAVE) |=> !display_sync_oe && !display_sync_out)
    else $error("slave drives the sync pin");

  a_sync_align: assert property (
    (s_reg.mode == LCDMS_SLAVE && sync_rise) |=> s_reg.line == LCDMS_LINE_ZERO)
    else $error("slave did not restart frame on sync");

  a_line_advance: assert property (
    (s_reg.mode == LCDMS_MASTER && tick_rise && s_reg.line < LAST_LINE) |=>
      s_reg.line == $past(s_reg.line) + LCDMS_LINE_STEP)
    else $error("line counter did not advance on rising edge");

  a_pattern_fall: assert property (
    (s_reg.mode != LCDMS_STRAP && tick_fall) |=> line_pattern == $past(s_reg.line))
    else $error("pattern not presented on falling edge");

  // the flag lags the mode by one edge, so it is judged against the past mode
  a_master_flag: assert property (
    (s_reg.mode != LCDMS_STRAP) |=> (is_master == ($past(s_reg.mode) == LCDMS_MASTER)))
    else $error("master flag does not match latched mode");

  // the strap is taken once; only a reset may change the mode again
  a_mode_locked: assert property (
    (s_reg.mode != LCDMS_STRAP) |=> s_reg.mode == $past(s_reg.mode))
    else $error("mode changed without reset");

  a_osc_master_on: assert property (
    (s_reg.mode == LCDMS_MASTER) |=> osc_amp_oe)
    else $error("oscillator amplifier idle in master mode");

  // a master ignores the sync pin; only the line clock moves its count
  a_master_line_hold: assert property (
    (s_reg.mode == LCDMS_MASTER && !tick_rise) |=> s_reg.line == $past(s_reg.line))
    else $error("master line counter moved without line clock rise");

  // sync and line clock rising together: the frame restart must win
  a_sync_priority: assert property (
    (s_reg.mode == LCDMS_SLAVE && sync_rise && tick_rise) |=> s_reg.line == LCDMS_LINE_ZERO)
    else $error("line clock rise overrode the sync restart");

  a_pattern_hold: assert property (
    (s_reg.mode != LCDMS_STRAP && !tick_fall) |=> line_pattern == $past(line_pattern))
    else $error("pattern changed away from a falling edge");

  // main scenarios: master wrap, slave restart, slave polarity flip, restart race
  c_master_wrap: cover property (s_reg.mode == LCDMS_MASTER && display_sync_out);
  c_slave_sync:  cover property (s_reg.mode == LCDMS_SLAVE && sync_rise);
  c_slave_flip:  cover property (s_reg.mode == LCDMS_SLAVE && $changed(ac_polarity_level));
  c_sync_tick:   cover property (s_reg.mode == LCDMS_SLAVE && sync_rise && tick_rise);

endmodule

`default_nettype wire

// [tb/lcdms_peer.sv]
/*
  lcdms_peer: far side of the shared polarity and sync nets, standing for
  a master chip and the common row driver.
  assumes: the bench resolves the nets and feeds them back in.
*/
`timescale 1ns/1ns
`default_nettype none

module lcdms_peer (
  input  wire logic clock,
  input  wire logic act_master,
  input  wire logic ac_set,
  input  wire logic sync_req,
  input  wire logic ac_net,
  output logic      ac_out,
  output logic      ac_oe,
  output logic      sync_out,
  output logic      sync_oe,
  output logic      ac_seen
);
  // drive only while standing in as master, else leave the nets alone
  assign ac_oe   = act_master;
  assign sync_oe = act_master;
  // registered like a real chip; the row driver only listens to the net
  always_ff @(posedge clock) begin
    ac_out   <= ac_set;
    sync_out <= sync_req;
    ac_seen  <= ac_net;
  end
endmodule

`default_nettype wire

// [tb/lcdms_timing_tb.sv]
/*
  lcdms_timing_tb: random and corner tests of master and slave modes.
  assumes: lcdms_pkg and lcdms_peer compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module lcdms_timing_tb;
  import lcdms_pkg::*;
  localparam logic [7:0] LPF = 8'h04;
  logic clock = 1'b0, reset = 1'b1, ms = 1'b1, fb = 1'b0, tick_in = 1'b0;
  logic pm = 1'b0, pac = 1'b0, psync = 1'b0, flt = 1'b0, pol;
  logic ac_out, ac_oe, sy_out, sy_oe, p_ac, p_acoe, p_sy, p_syoe, seen, amp, amp_oe, mst, lvl;
  logic ac_net, sy_net;
  logic [7:0] pat;
  int err_total = 0, total_checks = 0, n;

  always #50 clock = ~clock;
  // released nets show a pattern that flips every cycle
  always @(posedge clock) flt <= ~flt;
  assign ac_net = ac_oe ? ac_out : (p_acoe ? p_ac : flt);
  assign sy_net = sy_oe ? sy_out : (p_syoe ? p_sy : flt);

  lcdms_timing #(.LINES_PER_FRAME(LPF)) dut (.clock(clock), .reset(reset),
    .master_select(ms), .osc_feedback_in(fb), .osc_amp_out(amp), .osc_amp_oe(amp_oe),
    .row_tick_input(tick_in), .ac_polarity_signal_in(ac_net),
    .ac_polarity_signal_out(ac_out), .ac_polarity_signal_oe(ac_oe),
    .display_sync_in(sy_net), .display_sync_out(sy_out), .display_sync_oe(sy_oe),
    .is_master(mst), .ac_polarity_level(lvl), .line_pattern(pat));
  lcdms_peer peer (.clock(clock), .act_master(pm), .ac_set(pac), .sync_req(psync),
    .ac_net(ac_net), .ac_out(p_ac), .ac_oe(p_acoe), .sync_out(p_sy), .sync_oe(p_syoe),
    .ac_seen(seen));

  // expected line index after a given number of line clocks
  function automatic logic [7:0] exp_line(input int k);
    return 8'(k % LPF);
  endfunction

  task automatic do_reset(input logic m);
    reset = 1'b1;
    ms = m;
    pm = ~m;
    n = 0;
    pol = 1'b0;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    `CHK("is_master", m, mst)
    `CHK("ac_oe", m, ac_oe)
    `CHK("sync_oe", m, sy_oe)
    `CHK("amp_oe", m, amp_oe)
  endtask

  // one line clock: rise, then fall one cycle later
  task automatic tick(input logic m);
    n++;
    tick_in = 1'b1;
    @(negedge clock);
    if (m) begin
      if (n % LPF == 0) pol = ~pol;
      `CHK("sync_pulse", 1'(n % LPF == 0), sy_out)
      `CHK("ac_out", pol, ac_out)
    end
    tick_in = 1'b0;
    @(negedge clock);
    `CHK("line_pattern", exp_line(n), pat)
    if (m) begin
      `CHK("sync_end", 1'b0, sy_out)
      `CHK("row_drv_ac", pol, seen)
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    finish_test();
  end

  initial begin
    void'($urandom(32'had170b6a));
    @(negedge clock);
    // master: oscillator runs, polarity and sync driven, frames wrap
    do_reset(1'b1);
    repeat (8) begin
      fb = 1'($urandom);
      @(negedge clock);
      `CHK("osc_amp", ~fb, amp)
    end
    repeat (2 * LPF + 1 + ($urandom % 3)) tick(1'b1);
    `CHK("ac_level", pol, lvl)
    // slave: all pins released, levels follow the master peer
    do_reset(1'b0);
    repeat (4) begin
      fb = 1'($urandom);
      @(negedge clock);
      `CHK("osc_off", 1'b0, amp)
    end
    repeat (8) begin
      pac = 1'($urandom);
      repeat (2) @(negedge clock);
      `CHK("ac_follow", pac, lvl)
    end
    tick(1'b0);
    tick(1'b0);
    // sync lands between rise and fall, so the fall shows line zero
    tick_in = 1'b1;
    psync = 1'b1;
    @(negedge clock);
    psync = 1'b0;
    repeat (2) @(negedge clock);
    n = 0;
    tick_in = 1'b0;
    repeat (2) @(negedge clock);
    `CHK("slave_align", 8'h00, pat)
    tick(1'b0);
    // corner: sync and line clock rise at one edge, the restart must win
    psync = 1'b1;
    @(negedge clock);
    psync = 1'b0;
    tick_in = 1'b1;
    @(negedge clock);
    tick_in = 1'b0;
    repeat (2) @(negedge clock);
    `CHK("sync_priority", 8'h00, pat)
    n = 0;
    tick(1'b0);
    finish_test();
  end
endmodule

`undef CHK
`default_nettype wire
